// ### inc/crc_if.sv
`timescale 1ns/1ns
interface crc_if;
    logic clear;
    logic step;
    logic [7:0] dataByte;
    logic [15:0] crc16;
    logic [31:0] crc32;
    modport engine(input clear, input step, input dataByte, output crc16, output crc32);
    modport user(output clear, output step, output dataByte, input crc16, input crc32);
endinterface

// ### inc/ctl_frame_cfg.svh
`ifndef CTL_FRAME_CFG_SVH
`define CTL_FRAME_CFG_SVH
`define HDR_BYTES 7'd64
`define OFF_START_HI 6'h00
`define OFF_START_LO 6'h01
`define OFF_PROTO_REV 6'h02
`define OFF_COMMAND 6'h03
`define OFF_STATUS 6'h05
`define OFF_FLAGS_LO 6'h07
`define OFF_LEN_0 6'h08
`define OFF_LEN_3 6'h0B
`define OFF_ADDR_HI 6'h0C
`define OFF_ADDR_LO 6'h0D
`define OFF_PCRC_0 6'h3A
`define OFF_PCRC_3 6'h3D
`define OFF_HCRC_HI 6'h3E
`define OFF_HCRC_LO 6'h3F
`define START_ID 16'hA1EC
`define PROTO_REV 8'h03
`define CMD_REG_WRITE 8'h04
`define CMD_RESET 8'h07
`define FLAG_SKIP_PCRC 0
`define ST_OK 8'h00
`define ST_HDR_CRC 8'hFB
`define ST_PAY_CRC 8'hFC
`define ST_UNKNOWN 8'hFF
`define CRC16_POLY 16'h1021
`define CRC16_INIT 16'h0000
`define CRC32_POLY 32'h04C1_1DB7
`define CRC32_INIT 32'h0FFF_FFFF
`endif

// ### inc/ctl_frame_pkg.sv
package ctl_frame_pkg;
    typedef enum logic [2:0] {
        RX_HDR = 3'b000,
        RX_DATA = 3'b001,
        EVAL = 3'b010,
        WAIT_DONE = 3'b011,
        TX_HDR = 3'b100
    } phase_t;
endpackage

// ### logic/control_frame_write_reset.sv
// How it works
// - Header checksum: CRC-CCITT, poly 1021, init zero
// - Payload checksum: CRC-32, 04C11DB7, printed init
// - Header checksum at 3E covers 02..3D
// - Frames start with A1EC, high byte first
// - Byte 02 carries protocol version 03
// - Write response carries command code 04
// - Write response status byte holds result
// - Write response echoes start address at 0C
// - No payload: length and payload checksum zero
// - Flag bit 0 skips payload CRC check
// - Reset uses code 07, reply echoes it
// - Reserved and spare header bytes ignored
// - Reset frame flags carry no meaning
// - Reset response status holds result code
// - Status 00 ok, FB, FC, FF errors
`timescale 1ns/1ns
`include "ctl_frame_cfg.svh"
module control_frame_write_reset #(
    parameter int MAX_PAYLOAD = 256 // Write payload size in bytes; only checked to be even and at least 2, frame length is not limited by it
) (
    input wire logic clk, // 10 MHz clock
    input wire logic rst_n, // Synchronous reset, low
    input wire logic ce, // Clock enable
    input wire logic [7:0] rxByte, // Command byte
    input wire logic rxValid, // Command byte strobe
    output logic rxReady, // Command byte accepted
    output logic [7:0] txByte, // Response byte
    output logic txValid, // Response byte strobe
    input wire logic txReady, // Response byte taken
    output logic wrReq, // Register write pulse
    output logic [15:0] wrAddr, // Register address
    output logic [15:0] wrData, // Register value
    output logic rstReq, // Reset request pulse
    input wire logic opDone, // Write or reset finished
    input wire logic [7:0] opStatus // Result code of operation
);
    if (MAX_PAYLOAD < 2 || MAX_PAYLOAD % 2 != 0) begin : g_bad_payload
        $error("MAX_PAYLOAD must be even and at least 2");
    end

    ctl_frame_pkg::phase_t phase, next_phase;
    logic [5:0] idx, next_idx;
    logic [31:0] dataLeft, next_dataLeft;
    logic [7:0] cmd, next_cmd;
    logic skipPcrc, next_skipPcrc;
    logic [15:0] addr, next_addr;
    logic [31:0] len, next_len;
    logic [31:0] pcrcRx, next_pcrcRx;
    logic [15:0] hcrcRx, next_hcrcRx;
    logic [15:0] startId, next_startId;
    logic [7:0] proto, next_proto;
    logic [7:0] status, next_status;
    logic [15:0] hcrcHold, next_hcrcHold;
    logic [15:0] pcrcGood, next_pcrcGood;
    logic hiByte, next_hiByte;
    logic [7:0] dataHi, next_dataHi;
    logic [15:0] regPtr, next_regPtr;
    logic next_wrReq, next_rstReq;
    logic [15:0] next_wrAddr, next_wrData;
    logic [7:0] next_txByte;

    crc_if crc();
    crc_engine u_crc (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .crc(crc.engine)
    );

    assign rxReady = (phase == ctl_frame_pkg::RX_HDR) || (phase == ctl_frame_pkg::RX_DATA);
    assign txValid = (phase == ctl_frame_pkg::TX_HDR);

    // Byte for the next offset, so the response byte leaves a flip-flop
    always_comb begin
        next_txByte = 8'h00; // reserved/spare/flags sent as zero, length and CRC32 zero
        case (next_idx)
            `OFF_START_HI: next_txByte = 8'(`START_ID >> 8);
            `OFF_START_LO: next_txByte = 8'(`START_ID);
            `OFF_PROTO_REV: next_txByte = `PROTO_REV;
            `OFF_COMMAND: next_txByte = next_cmd;
            `OFF_STATUS: next_txByte = next_status;
            `OFF_ADDR_HI: next_txByte = (next_cmd == `CMD_REG_WRITE) ? next_addr[15:8] : 8'h00;
            `OFF_ADDR_LO: next_txByte = (next_cmd == `CMD_REG_WRITE) ? next_addr[7:0] : 8'h00;
            `OFF_HCRC_HI: next_txByte = next_hcrcHold[15:8];
            `OFF_HCRC_LO: next_txByte = next_hcrcHold[7:0];
            default: next_txByte = 8'h00;
        endcase
    end

    always_comb begin
        next_phase = phase;
        next_idx = idx;
        next_dataLeft = dataLeft;
        next_cmd = cmd;
        next_skipPcrc = skipPcrc;
        next_addr = addr;
        next_len = len;
        next_pcrcRx = pcrcRx;
        next_hcrcRx = hcrcRx;
        next_startId = startId;
        next_proto = proto;
        next_status = status;
        next_hcrcHold = hcrcHold;
        next_pcrcGood = pcrcGood;
        next_hiByte = hiByte;
        next_dataHi = dataHi;
        next_regPtr = regPtr;
        next_wrReq = 1'b0;
        next_rstReq = 1'b0;
        next_wrAddr = wrAddr;
        next_wrData = wrData;
        crc.clear = 1'b0;
        crc.step = 1'b0;
        crc.dataByte = rxByte;
        case (phase)
            ctl_frame_pkg::RX_HDR: begin
                if (rxValid) begin
                    // Header CRC runs over 02..3D only
                    crc.clear = (idx == `OFF_START_LO) || (idx == `OFF_HCRC_LO);
                    crc.step = (idx >= `OFF_PROTO_REV) && (idx <= `OFF_PCRC_3);
                    case (idx)
                        `OFF_START_HI: next_startId[15:8] = rxByte;
                        `OFF_START_LO: next_startId[7:0] = rxByte;
                        `OFF_PROTO_REV: next_proto = rxByte;
                        `OFF_COMMAND: next_cmd = rxByte;
                        `OFF_FLAGS_LO: next_skipPcrc = rxByte[`FLAG_SKIP_PCRC];
                        `OFF_ADDR_HI: next_addr[15:8] = rxByte;
                        `OFF_ADDR_LO: next_addr[7:0] = rxByte;
                        `OFF_HCRC_HI: next_hcrcRx[15:8] = rxByte;
                        default: begin
                        end
                    endcase
                    if (idx >= `OFF_LEN_0 && idx <= `OFF_LEN_3)
                        next_len = {len[23:0], rxByte};
                    if (idx >= `OFF_PCRC_0 && idx <= `OFF_PCRC_3)
                        next_pcrcRx = {pcrcRx[23:0], rxByte};
                    if (idx == `OFF_PCRC_3)
                        next_hcrcHold = crc.crc16;
                    if (idx == `OFF_PCRC_3)
                        next_hcrcHold = next_crc16_of(crc.crc16, rxByte);
                    next_idx = idx + 6'd1;
                    if (idx == `OFF_HCRC_LO) begin
                        next_hcrcRx[7:0] = rxByte;
                        next_dataLeft = (cmd == `CMD_REG_WRITE) ? len : 32'd0;
                        next_hiByte = 1'b1;
                        next_regPtr = addr;
                        next_phase = ((cmd == `CMD_REG_WRITE) && (len != 32'd0))
                            ? ctl_frame_pkg::RX_DATA : ctl_frame_pkg::EVAL;
                    end
                end
            end
            ctl_frame_pkg::RX_DATA: begin
                if (rxValid) begin
                    crc.step = 1'b1;
                    next_hiByte = !hiByte;
                    if (hiByte)
                        next_dataHi = rxByte;
                    next_dataLeft = dataLeft - 32'd1;
                    if (dataLeft == 32'd1)
                        next_phase = ctl_frame_pkg::EVAL;
                end
            end
            ctl_frame_pkg::EVAL: begin
                // Payload words are only released after the header CRC passes and the payload CRC passes, unless flag bit 0 skips that check
                if (startId != `START_ID || proto != `PROTO_REV)
                    next_status = `ST_UNKNOWN;
                else if (hcrcHold != hcrcRx)
                    next_status = `ST_HDR_CRC;
                else if (cmd == `CMD_REG_WRITE && !skipPcrc && len != 32'd0 && crc.crc32 != pcrcRx)
                    next_status = `ST_PAY_CRC;
                else if (cmd != `CMD_REG_WRITE && cmd != `CMD_RESET)
                    next_status = `ST_UNKNOWN;
                else
                    next_status = `ST_OK; // reset flags not consulted
                if (next_status == `ST_OK) begin
                    next_wrReq = (cmd == `CMD_REG_WRITE);
                    next_rstReq = (cmd == `CMD_RESET);
                    next_wrAddr = addr;
                    next_wrData = {dataHi, 8'h00};
                    next_phase = ctl_frame_pkg::WAIT_DONE;
                end else begin
                    next_idx = 6'd0;
                    next_phase = ctl_frame_pkg::TX_HDR;
                end
                crc.clear = 1'b1;
            end
            ctl_frame_pkg::WAIT_DONE: begin
                if (opDone) begin
                    next_status = opStatus; // answer once opDone reports the operation finished
                    next_idx = 6'd0;
                    next_phase = ctl_frame_pkg::TX_HDR;
                end
            end
            ctl_frame_pkg::TX_HDR: begin
                crc.dataByte = txByte;
                if (txReady) begin
                    crc.step = (idx >= `OFF_PROTO_REV) && (idx <= `OFF_PCRC_3);
                    if (idx == `OFF_PCRC_3)
                        next_hcrcHold = next_crc16_of(crc.crc16, txByte);
                    next_idx = idx + 6'd1;
                    if (idx == `OFF_HCRC_LO) begin
                        next_idx = 6'd0;
                        crc.clear = 1'b1;
                        next_phase = ctl_frame_pkg::RX_HDR;
                    end
                end
            end
            default: next_phase = ctl_frame_pkg::RX_HDR;
        endcase
    end

    function automatic logic [15:0] next_crc16_of(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c;
        for (int i = 7; i >= 0; i--)
            r = (r[15] ^ b[i]) ? ((r << 1) ^ `CRC16_POLY) : (r << 1);
        return r;
    endfunction

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            phase <= ctl_frame_pkg::RX_HDR;
            idx <= 6'd0;
            dataLeft <= 32'h0000_0000;
            cmd <= 8'h00;
            skipPcrc <= 1'b0;
            addr <= 16'h0000;
            len <= 32'h0000_0000;
            pcrcRx <= 32'h0000_0000;
            hcrcRx <= 16'h0000;
            startId <= 16'h0000;
            proto <= 8'h00;
            status <= 8'h00;
            hcrcHold <= 16'h0000;
            pcrcGood <= 16'h0000;
            hiByte <= 1'b1;
            dataHi <= 8'h00;
            regPtr <= 16'h0000;
            wrReq <= 1'b0;
            rstReq <= 1'b0;
            wrAddr <= 16'h0000;
            wrData <= 16'h0000;
            txByte <= 8'h00;
        end else if (ce) begin
            phase <= next_phase;
            idx <= next_idx;
            dataLeft <= next_dataLeft;
            cmd <= next_cmd;
            skipPcrc <= next_skipPcrc;
            addr <= next_addr;
            len <= next_len;
            pcrcRx <= next_pcrcRx;
            hcrcRx <= next_hcrcRx;
            startId <= next_startId;
            proto <= next_proto;
            status <= next_status;
            hcrcHold <= next_hcrcHold;
            pcrcGood <= next_pcrcGood;
            hiByte <= next_hiByte;
            dataHi <= next_dataHi;
            regPtr <= next_regPtr;
            wrReq <= next_wrReq;
            rstReq <= next_rstReq;
            wrAddr <= next_wrAddr;
            wrData <= next_wrData;
            txByte <= next_txByte;
        end
    end
endmodule

// ### logic/crc_engine.sv
`timescale 1ns/1ns
`include "ctl_frame_cfg.svh"
module crc_engine (
    input wire logic clk, // System clock
    input wire logic rst_n, // Synchronous reset
    input wire logic ce, // Clock enable
    crc_if.engine crc // Byte stream and results
);
    logic [15:0] next_crc16;
    logic [31:0] next_crc32;
    logic [15:0] c16;
    logic [31:0] c32;
    assign crc.crc16 = c16;
    assign crc.crc32 = c32;
    // MSB-first, unreflected update
    always_comb begin
        next_crc16 = c16;
        next_crc32 = c32;
        if (crc.clear) begin
            next_crc16 = `CRC16_INIT;
            next_crc32 = `CRC32_INIT;
        end else if (crc.step) begin
            for (int i = 7; i >= 0; i--) begin
                next_crc16 = (next_crc16[15] ^ crc.dataByte[i]) ?
                    ((next_crc16 << 1) ^ `CRC16_POLY) : (next_crc16 << 1);
                next_crc32 = (next_crc32[31] ^ crc.dataByte[i]) ?
                    ((next_crc32 << 1) ^ `CRC32_POLY) : (next_crc32 << 1);
            end
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            c16 <= `CRC16_INIT;
            c32 <= `CRC32_INIT;
        end else if (ce) begin
            c16 <= next_crc16;
            c32 <= next_crc32;
        end
    end
endmodule

// ### tb/frame_chk.sv
`timescale 1ns/1ns
module frame_chk (
    input wire logic clk, // Clock
    input wire logic rst_n, // Reset, low
    input wire logic ce, // Enable
    input wire logic [7:0] rxByte, // Command byte
    input wire logic rxValid, // Command strobe
    input wire logic rxReady, // Command accept
    input wire logic [7:0] txByte, // Response byte
    input wire logic txValid, // Response strobe
    input wire logic txReady, // Response taken
    input wire logic wrReq, // Write pulse
    input wire logic rstReq // Reset pulse
);
    logic [6:0] txOff;
    logic [7:0] rxOff;
    logic [7:0] capCmd;
    logic [15:0] capAddr;
    logic rxTake;
    assign rxTake = rxValid && rxReady && ce;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Offsets kept here so a slipped design counter cannot hide
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            txOff <= 7'h00;
            rxOff <= 8'h00;
            capCmd <= 8'h00;
            capAddr <= 16'h0000;
        end else begin
            txOff <= !txValid ? 7'h00 : (txReady && ce ? txOff + 7'h01 : txOff);
            rxOff <= txValid ? 8'h00 : (rxTake ? rxOff + 8'h01 : rxOff);
            if (rxTake && rxOff == 8'h03) capCmd <= rxByte;
            if (rxTake && rxOff == 8'h0C) capAddr[15:8] <= rxByte;
            if (rxTake && rxOff == 8'h0D) capAddr[7:0] <= rxByte;
        end
    end
    property p_pre; txValid && txOff < 7'h02 |-> txByte == (txOff[0] ? 8'hEC : 8'hA1); endproperty
    a_pre: assert property (p_pre) else $error("Bad start identifier");
    property p_ver; txValid && txOff == 7'h02 |-> txByte == 8'h03; endproperty
    a_ver: assert property (p_ver) else $error("Bad version byte");
    property p_cmd; txValid && txOff == 7'h03 && capCmd inside {8'h04, 8'h07} |-> txByte == capCmd; endproperty
    a_cmd: assert property (p_cmd) else $error("Command code not echoed");
    property p_zero; txValid && (txOff inside {[7'h08:7'h0B], [7'h3A:7'h3D]}) |-> txByte == 8'h00; endproperty
    a_zero: assert property (p_zero) else $error("Length or data checksum not zero");
    property p_addr; txValid && capCmd == 8'h04 && txOff[6:1] == 6'h06 |->
        txByte == (txOff[0] ? capAddr[7:0] : capAddr[15:8]); endproperty
    a_addr: assert property (p_addr) else $error("Address not echoed");
    property p_hold; txValid && !txReady |=> txValid && $stable(txByte); endproperty
    a_hold: assert property (p_hold) else $error("Response byte dropped");
    property p_busy; txValid |-> !rxReady; endproperty
    a_busy: assert property (p_busy) else $error("Command taken while answering");
    property p_wr; wrReq |-> capCmd == 8'h04 ##1 !wrReq && !rstReq; endproperty
    a_wr: assert property (p_wr) else $error("Bad write pulse");
    property p_rst; rstReq |-> capCmd == 8'h07 ##1 !rstReq && !wrReq; endproperty
    a_rst: assert property (p_rst) else $error("Bad reset pulse");
endmodule
bind control_frame_write_reset frame_chk CHK (.clk(clk), .rst_n(rst_n), .ce(ce), .rxByte(rxByte),
    .rxValid(rxValid), .rxReady(rxReady), .txByte(txByte), .txValid(txValid), .txReady(txReady),
    .wrReq(wrReq), .rstReq(rstReq));

// ### tb/host_model.sv
`timescale 1ns/1ns
module host_model (
    input wire logic clk, // Clock
    input wire logic rst_n, // Reset, low
    input wire logic ce, // Device clock enable
    input wire logic go, // Start frame
    input wire logic stall, // Slow reader
    input wire logic rxReady, // Device accepts
    input wire logic [7:0] txByte, // Response byte
    input wire logic txValid, // Response strobe
    output logic [7:0] rxByte, // Command byte
    output logic rxValid, // Command strobe
    output logic txReady // Response taken
);
    logic [7:0] frame [0:65];
    logic [7:0] resp [0:63];
    int nBytes;
    int idx;
    int rIdx;
    initial begin
        rxByte = 8'h00;
        rxValid = 1'b0;
        txReady = 1'b0;
    end
    always @(posedge clk) begin
        // Stall halves the take rate so each byte must stand
        txReady <= stall ? ~txReady : 1'b1;
        // A frozen device takes nothing, so the host must not move on
        if (txValid && txReady && ce && rIdx < 64) begin
            resp[rIdx] <= txByte;
            rIdx <= rIdx + 1;
        end
        if (!rst_n) begin
            rxValid <= 1'b0;
        end else if (go) begin
            idx <= 0;
            rIdx <= 0;
            rxValid <= 1'b1;
            rxByte <= frame[0];
        end else if (rxValid && rxReady && ce) begin
            idx <= idx + 1;
            rxValid <= idx + 1 < nBytes;
            rxByte <= idx + 1 < nBytes ? frame[idx + 1] : ~rxByte;
        end else if (!rxValid) begin
            rxByte <= ~rxByte; // Idle line never repeats the last byte
        end
    end
endmodule

// ### tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    typedef struct packed {
        logic [7:0] cmd;
        logic [7:0] ver;
        logic [15:0] flags;
        logic badH;
        logic badP;
        logic stall;
        logic [7:0] opSt;
        logic [7:0] expSt;
        logic expOp;
    } row_t;
    localparam row_t ROWS [0:8] = '{
        '{8'h04, 8'h03, 16'h0000, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 1'b1},
        '{8'h04, 8'h03, 16'h0000, 1'b0, 1'b0, 1'b1, 8'h0F, 8'h0F, 1'b1},
        '{8'h04, 8'h03, 16'h0000, 1'b1, 1'b0, 1'b0, 8'h00, 8'hFB, 1'b0},
        '{8'h04, 8'h03, 16'h0000, 1'b0, 1'b1, 1'b1, 8'h00, 8'hFC, 1'b0},
        '{8'h04, 8'h03, 16'h0001, 1'b0, 1'b1, 1'b0, 8'h00, 8'h00, 1'b1},
        '{8'h07, 8'h03, 16'hFFFF, 1'b0, 1'b0, 1'b1, 8'h00, 8'h00, 1'b1},
        '{8'h07, 8'h03, 16'h0000, 1'b0, 1'b0, 1'b0, 8'h0D, 8'h0D, 1'b1},
        '{8'h09, 8'h03, 16'h0000, 1'b0, 1'b0, 1'b0, 8'h00, 8'hFF, 1'b0},
        '{8'h04, 8'h02, 16'h0000, 1'b0, 1'b0, 1'b0, 8'h00, 8'hFF, 1'b0}};
    logic clk, rst_n, ce, ceGap, go, stall, rxValid, rxReady, txValid, txReady, wrReq, rstReq, opDone;
    logic [7:0] rxByte, txByte, opStatus;
    logic [15:0] wrAddr, wrData, gotAddr, gotData;
    int miscompares, nTests, nWr, nRst, cyc, waitC;
    control_frame_write_reset #(.MAX_PAYLOAD(256)) DUT (.clk(clk), .rst_n(rst_n), .ce(ce), .rxByte(rxByte),
        .rxValid(rxValid), .rxReady(rxReady), .txByte(txByte), .txValid(txValid), .txReady(txReady),
        .wrReq(wrReq), .wrAddr(wrAddr), .wrData(wrData), .rstReq(rstReq), .opDone(opDone), .opStatus(opStatus));
    host_model host (.clk(clk), .rst_n(rst_n), .ce(ce), .go(go), .stall(stall), .rxReady(rxReady), .txByte(txByte),
        .txValid(txValid), .rxByte(rxByte), .rxValid(rxValid), .txReady(txReady));
    function automatic logic [15:0] c16(input logic [15:0] c, input logic [7:0] b);
        for (int k = 7; k >= 0; k--) c = {c[14:0], 1'b0} ^ ((c[15] ^ b[k]) ? 16'h1021 : 16'h0000);
        return c;
    endfunction
    function automatic logic [31:0] c32(input logic [31:0] c, input logic [7:0] b);
        for (int k = 7; k >= 0; k--) c = {c[30:0], 1'b0} ^ ((c[31] ^ b[k]) ? 32'h04C1_1DB7 : 32'h0000_0000);
        return c;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
        end
    endtask
    task giveVerdict;
        $display("Comparisons %0d, mismatches %0d", nTests, miscompares);
        if (miscompares == 0 && nTests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic runRow(input int i, input logic abort);
        row_t r;
        logic [0:65][7:0] f;
        logic [15:0] h;
        logic [31:0] p;
        logic wr;
        int bw, br, k;
        r = ROWS[i];
        wr = r.cmd == 8'h04;
        for (k = 0; k < 66; k++) f[k] = 8'hA5 ^ k[7:0] ^ i[7:0];
        f[0:11] = {8'hA1, 8'hEC, r.ver, r.cmd, 8'h5A, 8'h33, r.flags, 24'h00_0000, wr ? 8'h02 : 8'h00};
        f[12:13] = {8'h12, i[7:0]};
        p = c32(c32(32'h0FFF_FFFF, 8'hBE), 8'hEF) ^ {31'h0000_0000, r.badP};
        f[58:61] = wr ? p : 32'h0000_0000;
        f[64:65] = 16'hBEEF;
        h = 16'h0000;
        for (k = 2; k < 62; k++) h = c16(h, f[k]);
        f[62:63] = h ^ {15'h0000, r.badH};
        for (k = 0; k < 66; k++) host.frame[k] = f[k];
        host.nBytes = wr ? 66 : 64;
        bw = nWr;
        br = nRst;
        stall <= r.stall;
        opStatus <= r.opSt;
        @(posedge clk);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        if (abort) begin
            repeat (20) @(posedge clk);
            rst_n <= 1'b0;
            repeat (10) @(posedge clk);
            check({rxReady, txValid, wrReq, rstReq}, 4'b1000);
            rst_n <= 1'b1;
            $display("Abort test done");
            return;
        end
        for (k = 0; k < 3000 && host.rIdx != 64; k++) @(posedge clk);
        repeat (2) @(posedge clk);
        check(host.resp[0], 8'hA1);
        check(host.resp[1], 8'hEC);
        check(host.resp[2], 8'h03);
        if (r.cmd inside {8'h04, 8'h07}) check(host.resp[3], r.cmd);
        check(host.resp[5], r.expSt);
        h = 16'h0000;
        for (k = 2; k < 62; k++) begin
            h = c16(h, host.resp[k]);
            if ((k >= 8 && k < 12) || k >= 58) check(host.resp[k], 8'h00);
        end
        check({host.resp[62], host.resp[63]}, h);
        if (wr) check({host.resp[12], host.resp[13]}, {8'h12, i[7:0]});
        check(nWr - bw, wr && r.expOp);
        check(nRst - br, !wr && r.expOp);
        if (wr && r.expOp) check({gotAddr, gotData}, {8'h12, i[7:0], 16'hBE00});
        $display("Row %0d done", i);
    endtask
    always #50 clk = ~clk;
    always @(posedge clk) begin
        opDone <= 1'b0;
        if (wrReq) begin
            nWr++;
            gotAddr <= wrAddr;
            gotData <= wrData;
        end
        if (rstReq) nRst++;
        if (!rst_n) waitC <= 0;
        else if (wrReq || rstReq) waitC <= 3;
        else if (waitC == 1) opDone <= 1'b1;
        if (rst_n && !wrReq && !rstReq && waitC > 0) waitC <= waitC - 1;
    end
    always @(posedge clk) begin
        // Freeze only while bytes move, so operation pulses stay one cycle
        ce <= !(ceGap && (txValid || rxValid) && cyc % 3 == 1);
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            giveVerdict;
        end
    end
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        ceGap = 1'b0;
        go = 1'b0;
        stall = 1'b0;
        opDone = 1'b0;
        opStatus = 8'h00;
        repeat (10) @(posedge clk);
        check({rxReady, txValid, wrReq, rstReq}, 4'b1000);
        rst_n <= 1'b1;
        $display("Reset test done");
        for (int i = 0; i < 9; i++) runRow(i, 1'b0);
        runRow(0, 1'b1);
        runRow(0, 1'b0);
        ceGap <= 1'b1;
        runRow(1, 1'b0);
        runRow(4, 1'b0);
        ceGap <= 1'b0;
        $display("Clock enable test done");
        giveVerdict;
    end
endmodule
